//--- plsr_pkg.sv
package plsr_pkg;
	localparam int          STAGES      = 8;
	localparam int          FIFO_DEPTH  = 32;
	localparam int          WORD_W      = STAGES + 2;
	localparam int          WORD_PAR_LSB = 0;
	localparam int          WORD_SER_BIT = STAGES;
	localparam int          WORD_SEL_BIT = STAGES + 1;
	localparam int          PIN_W       = STAGES + 4;
	localparam int          PIN_PAR_LSB = 0;
	localparam int          PIN_SER_BIT = STAGES;
	localparam int          PIN_SEL_BIT = STAGES + 1;
	localparam int          PIN_INH_BIT = STAGES + 2;
	localparam int          PIN_CLK_BIT = STAGES + 3;
	localparam logic [7:0]  STAGE_RESET = 8'h00;
endpackage

//--- plsr_fifo_if.sv
`timescale 1ns/1ps
interface plsr_fifo_if #(
	parameter int WIDTH = 10
);
	logic             in_valid;
	logic             in_ready;
	logic [WIDTH-1:0] in_data;
	logic             out_valid;
	logic             out_ready;
	logic [WIDTH-1:0] out_data;
	logic             flush;

	modport fifo_side (
		input  in_valid,
		output in_ready,
		input  in_data,
		output out_valid,
		input  out_ready,
		output out_data,
		input  flush
	);
	modport user_side (
		output in_valid,
		input  in_ready,
		output in_data,
		input  out_valid,
		output out_ready,
		input  out_data,
		output flush
	);
endinterface

//--- plsr_fifo.sv
`timescale 1ns/1ps
module plsr_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 32
) (
	input wire logic    i_clk_sys,
	input wire logic    i_rst_n,
	plsr_fifo_if.fifo_side port
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0]      wr_q;
	logic [AW:0]      wr_d;
	logic [AW:0]      rd_q;
	logic [AW:0]      rd_d;
	logic             empty_q;
	logic             empty_d;
	logic             ready_q;
	logic             ready_d;
	logic             push;
	logic             pop;

	////////////////////////////////////////////////////////////////////////
	assign push          = port.in_valid & ready_q;
	assign pop           = port.out_ready & ~empty_q;
	assign port.in_ready  = ready_q;
	assign port.out_valid = ~empty_q;
	assign port.out_data  = mem_q[rd_q[AW-1:0]];

	always_comb begin
		wr_d = wr_q + {{AW{1'b0}}, push};
		rd_d = rd_q + {{AW{1'b0}}, pop};
		if (port.flush) begin
			wr_d = '0;
			rd_d = '0;
		end
		empty_d = (wr_d == rd_d);
		ready_d = ~((wr_d[AW] != rd_d[AW]) &&
			(wr_d[AW-1:0] == rd_d[AW-1:0]));
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			wr_q    <= '0;
			rd_q    <= '0;
			empty_q <= 1'b1;
			ready_q <= 1'b1;
		end else begin
			wr_q    <= wr_d;
			rd_q    <= rd_d;
			empty_q <= empty_d;
			ready_q <= ready_d;
		end
	end

	// storage carries no reset; empty flag guards stale words
	always_ff @(posedge i_clk_sys) begin
		if (push) begin
			mem_q[wr_q[AW-1:0]] <= port.in_data;
		end
	end
endmodule

//--- plsr_top.sv
`timescale 1ns/1ps
//
// Contract
// - shift select high: first stage takes serial in, others predecessor
// - shift select low: parallel inputs captured on next active edge only
// - parallel input one lands in first stage, eight in final stage
// - serial input ignored during a parallel load
// - stages update only on clock rise while inhibit is low
// - either clock or inhibit held high accepts no new edge; edges already queued still apply while i_hold is low
// - active-low clear forces all stages and serial output to zero
// - only the final stage is visible outside the block
module plsr_top #(
	parameter int STAGES = plsr_pkg::STAGES,
	parameter int DEPTH  = plsr_pkg::FIFO_DEPTH
) (
	input  wire logic              i_clk_sys,
	input  wire logic              i_rst_n,
	input  wire logic              i_clear_n,
	input  wire logic              i_shift_clk,
	input  wire logic              i_clock_inhibit,
	input  wire logic              i_shift_load_select,
	input  wire logic              i_serial_in,
	input  wire logic [STAGES-1:0] i_parallel_in,
	input  wire logic              i_hold,
	output logic                   o_serial_out,
	output logic                   o_event_ready
);
	localparam int PW = plsr_pkg::PIN_W;
	localparam int WW = plsr_pkg::WORD_W;
	// clock pin idles high; resetting its history low would fake an edge
	localparam logic [PW-1:0] PIN_IDLE = {1'b1, {(PW-1){1'b0}}};

	logic [PW-1:0]     pin_meta_q;
	logic [PW-1:0]     pin_meta_d;
	logic [PW-1:0]     pin_sync_q;
	logic [PW-1:0]     pin_sync_d;
	logic              clr_meta_q;
	logic              clr_meta_d;
	logic              clr_sync_q;
	logic              clr_sync_d;
	logic              clk_prev_q;
	logic              clk_prev_d;
	logic              clk_event;
	logic [STAGES-1:0] stage_q;
	logic [STAGES-1:0] stage_d;
	logic              apply;
	logic              sel_w;
	logic              ser_w;
	logic [STAGES-1:0] par_w;

	plsr_fifo_if #(.WIDTH(WW)) evq ();

	////////////////////////////////////////////////////////////////////////
	// every pin except i_hold and i_rst_n passes two flops before logic looks at it; the stage clear also takes i_clear_n directly
	always_comb begin
		pin_meta_d = {i_shift_clk, i_clock_inhibit, i_shift_load_select,
			i_serial_in, i_parallel_in};
		pin_sync_d = pin_meta_q;
		clr_meta_d = i_clear_n;
		clr_sync_d = clr_meta_q;
		clk_prev_d = pin_sync_q[plsr_pkg::PIN_CLK_BIT];
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			pin_meta_q <= PIN_IDLE;
			pin_sync_q <= PIN_IDLE;
			clr_meta_q <= 1'b0;
			clr_sync_q <= 1'b0;
			clk_prev_q <= 1'b1;
		end else begin
			pin_meta_q <= pin_meta_d;
			pin_sync_q <= pin_sync_d;
			clr_meta_q <= clr_meta_d;
			clr_sync_q <= clr_sync_d;
			clk_prev_q <= clk_prev_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// edge of the clock pin, qualified by a low inhibit, is the enable;
	// looking at the inhibit level only means a late inhibit fall while
	// the clock is high cannot make a spurious edge
	assign clk_event = pin_sync_q[plsr_pkg::PIN_CLK_BIT] & ~clk_prev_q &
		~pin_sync_q[plsr_pkg::PIN_INH_BIT] & clr_sync_q;

	// each accepted edge is queued with the control and data seen at it;
	// when the queue is full the edge is lost and o_event_ready shows it
	assign evq.in_valid = clk_event;
	assign evq.in_data  = {pin_sync_q[plsr_pkg::PIN_SEL_BIT],
		pin_sync_q[plsr_pkg::PIN_SER_BIT],
		pin_sync_q[plsr_pkg::PIN_PAR_LSB +: STAGES]};
	assign evq.flush     = ~clr_sync_q;
	assign evq.out_ready = ~i_hold & clr_sync_q;
	assign apply         = evq.out_valid & evq.out_ready;

	plsr_fifo #(
		.WIDTH(WW),
		.DEPTH(DEPTH)
	) u_fifo (
		.i_clk_sys (i_clk_sys),
		.i_rst_n   (i_rst_n),
		.port      (evq)
	);

	assign sel_w = evq.out_data[plsr_pkg::WORD_SEL_BIT];
	assign ser_w = evq.out_data[plsr_pkg::WORD_SER_BIT];
	assign par_w = evq.out_data[plsr_pkg::WORD_PAR_LSB +: STAGES];

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		stage_d = stage_q;
		if (apply) begin
			if (sel_w) begin
				stage_d = {stage_q[STAGES-2:0], ser_w};
			end else begin
				stage_d = par_w;
			end
		end
	end

	// clear acts without the clock so it wins even with the clock stopped
	always_ff @(posedge i_clk_sys or negedge i_clear_n) begin
		if (!i_clear_n) begin
			stage_q <= plsr_pkg::STAGE_RESET[STAGES-1:0];
		end else if (!i_rst_n) begin
			stage_q <= plsr_pkg::STAGE_RESET[STAGES-1:0];
		end else begin
			stage_q <= stage_d;
		end
	end

	assign o_serial_out  = stage_q[STAGES-1];
	assign o_event_ready = evq.in_ready;
endmodule

//--- plsr_chk.sv
`timescale 1ns/1ps
module plsr_chk #(
	parameter int STAGES = 8
) (
	input wire logic              i_clk_sys,
	input wire logic              i_rst_n,
	input wire logic              i_clear_n,
	input wire logic              i_shift_clk,
	input wire logic              i_clock_inhibit,
	input wire logic              i_shift_load_select,
	input wire logic [STAGES-1:0] i_parallel_in,
	input wire logic              i_hold,
	input wire logic              o_serial_out,
	input wire logic              o_event_ready
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	sequence rise_s;
		!i_shift_clk ##1 i_shift_clk && i_clear_n && !i_hold;
	endsequence
	a_clear_zero: assert property (!i_clear_n |-> !o_serial_out)
		else $error("clear");
	a_clear_settle: assert property ($rose(i_clear_n) |-> !o_serial_out[*2])
		else $error("clear release");
	a_rise_source: assert property ($rose(o_serial_out) |-> $past(i_clear_n, 2))
		else $error("rise under clear");
	a_load_lands: assert property (rise_s ##0 !i_shift_load_select
		&& !i_clock_inhibit |-> ##[3:5] o_serial_out == i_parallel_in[STAGES-1])
		else $error("load");
	a_inhibit_rise: assert property (rise_s ##0 i_clock_inhibit
		|=> $stable(o_serial_out)[*6]) else $error("inhibit");
	a_inhibit_freeze: assert property ((i_clock_inhibit && !i_hold)[*8]
		|-> $stable(o_serial_out)) else $error("freeze");
	a_reset_exit: assert property ($rose(i_rst_n) |-> !o_serial_out && o_event_ready)
		else $error("reset");
	a_ready_back: assert property ($fell(i_hold) |-> ##[1:3] o_event_ready)
		else $error("ready");
endmodule
bind plsr_top plsr_chk #(.STAGES(STAGES)) u_chk (.*);

//--- plsr_drv.sv
`timescale 1ns/1ps
module plsr_drv (
	input  wire logic i_clk_sys,
	output logic      o_clk,
	output logic      o_inh,
	output logic      o_sel,
	output logic      o_ser,
	output logic [7:0] o_par
);
	initial {o_clk, o_inh, o_sel, o_ser, o_par} = 12'h800;
	// clock idles high so inhibit may change at step start
	task automatic step(input logic s, d, h, input logic [7:0] p);
		o_inh <= h;
		@(posedge i_clk_sys);
		{o_clk, o_sel, o_ser, o_par} <= {1'h0, s, d, p};
		repeat (2) @(posedge i_clk_sys);
		o_clk <= 1'h1;
		repeat (5) @(posedge i_clk_sys);
	endtask
endmodule

//--- plsr_top_tb.sv
`timescale 1ns/1ps
module plsr_top_tb;
	logic i_clk_sys = 1'h0, i_rst_n = 1'h0, i_clear_n = 1'h1, i_hold = 1'h0;
	logic i_shift_clk, i_clock_inhibit, i_shift_load_select, i_serial_in;
	logic o_serial_out, o_event_ready;
	logic [7:0] i_parallel_in, m = 8'h00;
	logic [31:0] rs = 32'h000141B7;
	int err_total = 0, check_count = 0, cyc = 0;
	always #20 i_clk_sys = ~i_clk_sys;
	plsr_top DUT (.*);
	plsr_drv u_drv (.i_clk_sys(i_clk_sys), .o_clk(i_shift_clk),
		.o_inh(i_clock_inhibit), .o_sel(i_shift_load_select),
		.o_ser(i_serial_in), .o_par(i_parallel_in));
	function automatic logic [31:0] nx(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction
	task automatic chk(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %0t output mismatch", $time);
		end
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic go(input logic s, d, h, input logic [7:0] p);
		u_drv.step(s, d, h, p);
		if (!h) m = s ? {m[6:0], d} : p;
		chk(o_serial_out, m[7]);
	endtask
	always @(posedge i_clk_sys) begin
		cyc++;
		if (cyc > 5000) begin
			err_total++;
			summarize();
		end
	end
	initial begin
		repeat (5) @(posedge i_clk_sys);
		i_rst_n <= 1'h1;
		repeat (3) @(posedge i_clk_sys);
		go(1'h0, 1'h1, 1'h0, 8'h80);
		go(1'h1, 1'h0, 1'h1, 8'h00);
		for (int i = 0; i < 120; i++) begin
			rs = nx(rs);
			go(rs[0], rs[1], rs[3:2] == 2'h0, rs[15:8]);
		end
		go(1'h0, 1'h0, 1'h0, 8'hFF);
		i_clear_n <= 1'h0;
		@(posedge i_clk_sys);
		#1 chk(o_serial_out, 1'h0);
		m = 8'h00;
		@(posedge i_clk_sys);
		i_clear_n <= 1'h1;
		repeat (4) @(posedge i_clk_sys);
		i_hold <= 1'h1;
		for (int i = 0; i < 32; i++) begin
			rs = nx(rs);
			u_drv.step(1'h1, rs[0], 1'h0, rs[15:8]);
			m = {m[6:0], rs[0]};
		end
		chk(o_event_ready, 1'h0); // buffer full
		i_hold <= 1'h0;
		repeat (40) @(posedge i_clk_sys);
		chk(o_serial_out, m[7]);
		chk(o_event_ready, 1'h1);
		i_rst_n <= 1'h0;
		repeat (3) @(posedge i_clk_sys);
		i_rst_n <= 1'h1;
		#1 chk(o_serial_out, 1'h0);
		chk(o_event_ready, 1'h1);
		m = 8'h00;
		repeat (3) @(posedge i_clk_sys);
		go(1'h0, 1'h0, 1'h0, 8'hA5);
		summarize();
	end
endmodule
